// [dv/tmw_counter_core_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// Port checker for the wrap-value block.
module tmw_counter_core_properties (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Register port.
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Counter side.
    input wire logic COUNT_TICK,
    input wire logic WRAP_FLAG,
    input wire logic [15:0] COUNT,
    input wire logic [15:0] WRAP_VALUE
);
    logic [1:0] sel_r; // Clock select as last written.
    logic dbg_r; // Debug level as last written.
    logic half_r; // One wrap byte is outstanding.
    logic [15:0] buf_r; // Wrap bytes written outside debug.
    logic [15:0] nv_r; // Value the last wrap write should make.
    logic wlo; // Write to the low wrap byte.
    logic whi; // Write to the high wrap byte.
    logic wsc; // Write to status/control.
    assign wlo = WR && ADDR == tmw_pkg::ADDR_WRAP_LOW;
    assign whi = WR && ADDR == tmw_pkg::ADDR_WRAP_HIGH;
    assign wsc = WR && ADDR == tmw_pkg::ADDR_STATUS_CTRL;
    // Mirrors mode bits and the byte pairing seen by software.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sel_r <= 2'h0;
            dbg_r <= 1'b0;
            half_r <= 1'b0;
            buf_r <= 16'h0000;
            nv_r <= 16'h0000;
        end else begin
            if (wsc) begin
                sel_r <= WDATA[tmw_pkg::CLKSEL_LSB +: 2];
                half_r <= 1'b0;
            end else if ((wlo || whi) && !dbg_r) begin
                half_r <= ~half_r;
            end
            if (WR && ADDR == tmw_pkg::ADDR_DEBUG) begin
                dbg_r <= WDATA[0];
            end
            if (wlo) begin
                nv_r <= {buf_r[15:8], WDATA};
            end else if (whi) begin
                nv_r <= {WDATA, buf_r[7:0]};
            end
            if (wlo && !dbg_r) begin
                buf_r[7:0] <= WDATA;
            end else if (whi && !dbg_r) begin
                buf_r[15:8] <= WDATA;
            end
        end
    end
    AST_RESET_ZERO: assert property (
        @(posedge CLK_SYS) RST |-> WRAP_VALUE == 16'h0000 && COUNT == 16'h0000)
        else $error("wrap value not cleared by reset");
    AST_WRAP_ZERO: assert property (@(posedge CLK_SYS) disable iff (RST)
        $changed(COUNT) && $past(COUNT) == $past(WRAP_VALUE) && $past(WRAP_VALUE) != 16'h0000
        && $stable(WRAP_VALUE) |-> COUNT == 16'h0000)
        else $error("counter did not restart at zero");
    AST_FLAG_RISE: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(WRAP_FLAG) |-> COUNT == 16'h0000 || $past(COUNT) == 16'h0000)
        else $error("flag set without a wrap");
    AST_FLAG_FALL: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(WRAP_FLAG) |-> $past(wsc) && !$past(WDATA[tmw_pkg::FLAG_BIT]))
        else $error("flag cleared without a status write");
    AST_SUPPRESS: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(WRAP_FLAG) |-> !(half_r && $past(half_r)))
        else $error("flag set while one byte pending");
    AST_NOCLK_APPLY: assert property (@(posedge CLK_SYS) disable iff (RST)
        (wlo || whi) && half_r && !dbg_r && sel_r == 2'h0 |-> ##[2:3] WRAP_VALUE == nv_r)
        else $error("second byte did not apply the value");
    AST_UPDATE_POINT: assert property (@(posedge CLK_SYS) disable iff (RST)
        $changed(WRAP_VALUE) && sel_r != 2'h0 && $past(sel_r, 3) != 2'h0 && !dbg_r
        && !$past(dbg_r, 3) |-> $past(COUNT) == $past(WRAP_VALUE)
        || ($past(WRAP_VALUE) == 16'h0000 && $past(COUNT) == 16'hFFFF))
        else $error("wrap value applied off the update point");
    AST_DEBUG_WRITE: assert property (@(posedge CLK_SYS) disable iff (RST)
        wlo && dbg_r |-> ##[2:3] WRAP_VALUE[7:0] == nv_r[7:0])
        else $error("debug write did not reach the wrap value");
endmodule
bind tmw_counter_core tmw_counter_core_properties tmw_counter_core_properties_i (
    .CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .COUNT_TICK(COUNT_TICK), .WRAP_FLAG(WRAP_FLAG), .COUNT(COUNT),
    .WRAP_VALUE(WRAP_VALUE));
`default_nettype wire

// [dv/tmw_counter_core_tb.sv]
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the wrap-value block.
module tmw_counter_core_tb;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic COUNT_TICK = 1'b0;
    logic [7:0] RDATA;
    logic WRAP_FLAG;
    logic [15:0] COUNT;
    logic [15:0] WRAP_VALUE;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int tick_mode = 0; // Zero off, one random, two every cycle.
    logic [15:0] v;
    logic [7:0] rb;
    tmw_counter_core tmw_counter_core_i (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .COUNT_TICK(COUNT_TICK),
        .WRAP_FLAG(WRAP_FLAG), .COUNT(COUNT), .WRAP_VALUE(WRAP_VALUE));
    initial begin
        forever #2 CLK_SYS = ~CLK_SYS;
    end
    // Ticks at the chosen rate, and a cycle ceiling against hangs.
    always @(posedge CLK_SYS) begin
        COUNT_TICK <= tick_mode == 2 || (tick_mode == 1 && $urandom_range(1) == 1);
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        wt(1);
        WR <= 1'b0;
        wt(1);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        RD <= 1'b1;
        ADDR <= a;
        wt(1);
        RD <= 1'b0;
        #1 d = RDATA;
        wt(1);
    endtask
    task automatic pair(input logic [15:0] val);
        wr(tmw_pkg::ADDR_WRAP_LOW, val[7:0]);
        wr(tmw_pkg::ADDR_WRAP_HIGH, val[15:8]);
    endtask
    task automatic latch_is(input logic [15:0] exp);
        rd(tmw_pkg::ADDR_LATCH_STATE, rb);
        check(rb, exp);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        // Raise reset after every process waits, so the flops see its edge.
        RST <= 1'b1;
        void'($urandom(32'h6F52));
        wt(8);
        RST <= 1'b0;
        wt(1);
        check(WRAP_VALUE, 16'h0000);
        latch_is(16'(tmw_pkg::LATCH_IDLE));
        $display("test reset done");
        v = 16'($urandom());
        wr(tmw_pkg::ADDR_WRAP_HIGH, v[15:8]);
        latch_is(16'(tmw_pkg::LATCH_ONE));
        check(WRAP_VALUE, 16'h0000);
        wr(tmw_pkg::ADDR_WRAP_LOW, v[7:0]);
        wt(2);
        check(WRAP_VALUE, v);
        v = 16'h0008 + 16'($urandom_range(7));
        pair(v);
        $display("test idle clock done");
        wr(tmw_pkg::ADDR_STATUS_CTRL, 8'h08);
        tick_mode = 1;
        pair(v + 16'h0004);
        check(WRAP_VALUE, v);
        for (int i = 0; i < 300 && WRAP_VALUE !== v + 16'h0004; i++) wt(1);
        for (int i = 0; i < 300 && WRAP_FLAG !== 1'b1; i++) wt(1);
        check(WRAP_FLAG, 1'b1);
        check(COUNT <= v + 16'h0004, 1'b1);
        tick_mode = 0;
        wt(2);
        rd(tmw_pkg::ADDR_STATUS_CTRL, rb);
        wr(tmw_pkg::ADDR_STATUS_CTRL, 8'h08);
        check(WRAP_FLAG, 1'b0);
        tick_mode = 1;
        wr(tmw_pkg::ADDR_WRAP_LOW, 8'h20);
        wt(150);
        check(WRAP_FLAG, 1'b0);
        wr(tmw_pkg::ADDR_STATUS_CTRL, 8'h08);
        for (int i = 0; i < 300 && WRAP_FLAG !== 1'b1; i++) wt(1);
        check(WRAP_FLAG, 1'b1);
        $display("test update point done");
        tick_mode = 0;
        wr(tmw_pkg::ADDR_STATUS_CTRL, 8'h00);
        pair(16'h0000);
        wr(tmw_pkg::ADDR_STATUS_CTRL, 8'h08);
        tick_mode = 2;
        v = 16'h0100 | 16'($urandom());
        pair(v);
        for (int i = 0; i < 70000 && COUNT !== 16'hFFFF; i++) wt(1);
        tick_mode = 0;
        wt(4);
        check(WRAP_VALUE, v);
        $display("test free running done");
        wr(tmw_pkg::ADDR_STATUS_CTRL, 8'h00);
        wr(tmw_pkg::ADDR_WRAP_LOW, 8'h5A);
        wr(tmw_pkg::ADDR_DEBUG, 8'h01);
        wr(tmw_pkg::ADDR_WRAP_HIGH, 8'hC3);
        wr(tmw_pkg::ADDR_WRAP_LOW, 8'h3C);
        // The output register follows the active value one edge later.
        wt(1);
        check(WRAP_VALUE, 16'hC33C);
        latch_is(16'(tmw_pkg::LATCH_ONE));
        wr(tmw_pkg::ADDR_STATUS_CTRL, 8'h00);
        latch_is(16'(tmw_pkg::LATCH_IDLE));
        wr(tmw_pkg::ADDR_DEBUG, 8'h00);
        $display("test debug done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// [hdl/tmw_counter_core.sv]
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Top of the timer wrap-value block with a minimal counter.
// Function
// - At wrap value, restart count at zero.
// - Wrap to zero sets the wrap flag.
// - Half-written wrap value suppresses the flag.
// - Reset clears wrap value; zero means free-running.
// - Wrap byte writes outside debug go to a buffer.
// - No clock selected: apply at second byte.
// - Clock selected: apply at old value minus one.
// - Free running: apply stepping FFFE to FFFF.
// - Status/control write resets byte latching.
// - Debug mode freezes the coherency latches; a status/control write still resets them.
// - Debug writes bypass buffer into active value.
module tmw_counter_core (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Register port.
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Counting clock tick from the prescaler, same clock domain.
    input wire logic COUNT_TICK,
    // Status outputs.
    output logic WRAP_FLAG,
    output logic [15:0] COUNT,
    output logic [15:0] WRAP_VALUE
);
    tmw_wrap_if wp ();

    logic [1:0] clk_sel_r; // Clock source select.
    logic flag_r; // Counter wrap flag.
    logic flag_armed_r; // Flag was read set, clear allowed.
    logic dbg_r; // Debug mode active.
    logic [15:0] count_r; // Timer counter.
    logic [15:0] count_nxt; // Next counter value.
    logic [7:0] rdata_r; // Read data register.
    logic counting; // Counter advances this cycle.
    logic wraps; // Counter wraps this cycle.
    logic sc_wr; // Write to status/control.
    logic [7:0] sc_view; // Status/control readback.

    // Address compare used for every decode except the read-data mux.
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
        hit = (a == ref_a);
    endfunction

    assign sc_wr = WR & hit(ADDR, tmw_pkg::ADDR_STATUS_CTRL);
    assign counting = COUNT_TICK & (clk_sel_r != tmw_pkg::CLKSEL_NONE) & ~dbg_r;
    // Wrap against the active value only; zero wraps at full range.
    assign wraps = (wp.active == tmw_pkg::WRAP_RESET) ? (&count_r)
                                                      : (count_r == wp.active);

    // Next count: hold, step by one, or restart at zero.
    always_comb begin
        count_nxt = count_r;
        if (counting) begin
            if (wraps) begin
                count_nxt = tmw_pkg::COUNT_ZERO;
            end else begin
                count_nxt = 16'(count_r + 16'h0001);
            end
        end
    end

    // Interface drive toward the buffer.
    assign wp.wr_low = WR & hit(ADDR, tmw_pkg::ADDR_WRAP_LOW);
    assign wp.wr_high = WR & hit(ADDR, tmw_pkg::ADDR_WRAP_HIGH);
    assign wp.wdata = WDATA;
    assign wp.sc_write = sc_wr;
    assign wp.dbg = dbg_r;
    assign wp.clk_on = (clk_sel_r != tmw_pkg::CLKSEL_NONE);
    // Update point: old value minus one to old value, or FFFE to FFFF.
    assign wp.at_update = counting && ((wp.active == tmw_pkg::WRAP_RESET)
        ? (count_r == tmw_pkg::FREE_LAST_STEP)
        : (count_r == wp.active - 16'h0001));

    tmw_wrap_buffer u_buf (
        .clk(CLK_SYS),
        .rst(RST),
        .wp(wp)
    );

    // Counter register.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            count_r <= tmw_pkg::COUNT_ZERO;
        end else begin
            count_r <= count_nxt;
        end
    end

    // Control registers: clock select and debug mode.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            clk_sel_r <= tmw_pkg::CLKSEL_NONE;
            dbg_r <= 1'b0;
        end else begin
            if (sc_wr) begin
                clk_sel_r <= WDATA[tmw_pkg::CLKSEL_LSB +: 2];
            end
            if (WR && hit(ADDR, tmw_pkg::ADDR_DEBUG)) begin
                dbg_r <= WDATA[0];
            end
        end
    end

    // Wrap flag: set wins over clear; suppressed while half-written.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            flag_r <= 1'b0;
            flag_armed_r <= 1'b0;
        end else if (counting && wraps && !wp.pending) begin
            flag_r <= 1'b1;
            flag_armed_r <= 1'b0;
        end else begin
            if (RD && hit(ADDR, tmw_pkg::ADDR_STATUS_CTRL) && flag_r) begin
                flag_armed_r <= 1'b1;
            end
            // Clearing needs a read while set, then a write of zero.
            if (sc_wr && flag_armed_r && !WDATA[tmw_pkg::FLAG_BIT]) begin
                flag_r <= 1'b0;
                flag_armed_r <= 1'b0;
            end
        end
    end

    assign sc_view = {flag_r, 2'h0, clk_sel_r, 3'h0};

    // Read data, valid the cycle after the read strobe only.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rdata_r <= tmw_pkg::BYTE_ZERO;
        end else if (RD) begin
            case (ADDR)
                tmw_pkg::ADDR_WRAP_LOW: rdata_r <= wp.active[7:0];
                tmw_pkg::ADDR_WRAP_HIGH: rdata_r <= wp.active[15:8];
                tmw_pkg::ADDR_STATUS_CTRL: rdata_r <= sc_view;
                tmw_pkg::ADDR_COUNT_LOW: rdata_r <= count_r[7:0];
                tmw_pkg::ADDR_COUNT_HIGH: rdata_r <= count_r[15:8];
                tmw_pkg::ADDR_DEBUG: rdata_r <= {7'h00, dbg_r};
                tmw_pkg::ADDR_LATCH_STATE: rdata_r <= {6'h00, wp.state};
                default: rdata_r <= tmw_pkg::BYTE_ZERO;
            endcase
        end else begin
            rdata_r <= tmw_pkg::BYTE_ZERO;
        end
    end

    // Registered status outputs.
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            COUNT <= tmw_pkg::COUNT_ZERO;
            WRAP_VALUE <= tmw_pkg::WRAP_RESET;
        end else begin
            COUNT <= count_nxt;
            WRAP_VALUE <= wp.active;
        end
    end

    assign RDATA = rdata_r;
    assign WRAP_FLAG = flag_r;
endmodule
`default_nettype wire

// [hdl/tmw_pkg.sv]
// Shared constants for the timer wrap-value block.
package tmw_pkg;
    // Register offsets on the plain register port.
    localparam logic [3:0] ADDR_WRAP_LOW = 4'h0; // Low byte of the wrap value.
    localparam logic [3:0] ADDR_WRAP_HIGH = 4'h1; // High byte of the wrap value.
    localparam logic [3:0] ADDR_STATUS_CTRL = 4'h2; // Status/control: clock select, flag.
    localparam logic [3:0] ADDR_COUNT_LOW = 4'h3; // Counter value, low byte.
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h4; // Counter value, high byte.
    localparam logic [3:0] ADDR_DEBUG = 4'h5; // Debug-active control.
    localparam logic [3:0] ADDR_LATCH_STATE = 4'h6; // Coherency latch state, read only.
    // Field positions in the status/control register.
    localparam int CLKSEL_LSB = 3; // Clock source select, two bits.
    localparam int FLAG_BIT = 7; // Counter wrap flag.
    // Reset values and counter landmarks.
    localparam logic [15:0] WRAP_RESET = 16'h0000; // Zero means free running.
    localparam logic [15:0] COUNT_ZERO = 16'h0000; // Restart value of the counter.
    localparam logic [15:0] FREE_LAST_STEP = 16'hFFFE; // Free running update point.
    localparam logic [1:0] CLKSEL_NONE = 2'h0; // No clock selected.
    localparam logic [7:0] BYTE_ZERO = 8'h00; // Zero byte on reads.
    // Coherency latch states.
    typedef enum logic [1:0] {
        LATCH_IDLE,
        LATCH_ONE,
        LATCH_BOTH
    } tmw_latch_t;
endpackage

// [hdl/tmw_wrap_buffer.sv]
`timescale 1ns/10ps
`default_nettype none
// Write buffer and coherency latches for the 16-bit wrap value.
module tmw_wrap_buffer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Wrap-value port.
    tmw_wrap_if.buffer wp
);
    logic [15:0] buf_r; // Write buffer.
    logic [15:0] active_r; // Active wrap register.
    tmw_pkg::tmw_latch_t state_r; // Coherency latch state.
    logic got_low_r; // Low byte of this pair is buffered.
    logic got_high_r; // High byte of this pair is buffered.
    logic write_any; // Any wrap-byte write this cycle.
    logic completes; // This write completes the pair.

    assign write_any = wp.wr_low | wp.wr_high;
    assign completes = (wp.wr_low & got_high_r) | (wp.wr_high & got_low_r);

    // Buffer capture; debug writes skip the buffer entirely.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_r <= tmw_pkg::WRAP_RESET;
        end else if (!wp.dbg) begin
            if (wp.wr_low) begin
                buf_r[7:0] <= wp.wdata;
            end
            if (wp.wr_high) begin
                buf_r[15:8] <= wp.wdata;
            end
        end
    end

    // Latch tracking; frozen in debug except for a status/control write.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= tmw_pkg::LATCH_IDLE;
            got_low_r <= 1'b0;
            got_high_r <= 1'b0;
        end else if (wp.sc_write) begin
            // Status/control write discards a partial pair.
            state_r <= tmw_pkg::LATCH_IDLE;
            got_low_r <= 1'b0;
            got_high_r <= 1'b0;
        end else if (wp.dbg) begin
            state_r <= state_r;
        end else begin
            case (state_r)
                tmw_pkg::LATCH_IDLE: begin
                    if (write_any) begin
                        state_r <= tmw_pkg::LATCH_ONE;
                        got_low_r <= wp.wr_low;
                        got_high_r <= wp.wr_high;
                    end
                end
                tmw_pkg::LATCH_ONE: begin
                    if (completes && !wp.clk_on) begin
                        // No clock selected: apply at the second byte.
                        state_r <= tmw_pkg::LATCH_IDLE;
                        got_low_r <= 1'b0;
                        got_high_r <= 1'b0;
                    end else if (completes) begin
                        state_r <= tmw_pkg::LATCH_BOTH;
                        got_low_r <= 1'b1;
                        got_high_r <= 1'b1;
                    end
                end
                tmw_pkg::LATCH_BOTH: begin
                    // Apply when counter hits update point; removing the clock takes a status/control write, which discards the pair.
                    if (!wp.clk_on || wp.at_update) begin
                        state_r <= tmw_pkg::LATCH_IDLE;
                        got_low_r <= 1'b0;
                        got_high_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= tmw_pkg::LATCH_IDLE;
                end
            endcase
        end
    end

    // Active register update.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_r <= tmw_pkg::WRAP_RESET;
        end else if (wp.dbg) begin
            // Debug writes land directly in the active register.
            if (wp.wr_low) begin
                active_r[7:0] <= wp.wdata;
            end
            if (wp.wr_high) begin
                active_r[15:8] <= wp.wdata;
            end
        end else if (!wp.sc_write && state_r == tmw_pkg::LATCH_ONE && completes
                     && !wp.clk_on) begin
            active_r <= wp.wr_low ? {buf_r[15:8], wp.wdata}
                                  : {wp.wdata, buf_r[7:0]};
        end else if (!wp.sc_write && state_r == tmw_pkg::LATCH_BOTH
                     && (!wp.clk_on || wp.at_update)) begin
            active_r <= buf_r;
        end
    end

    assign wp.active = active_r;
    assign wp.pending = (state_r == tmw_pkg::LATCH_ONE);
    assign wp.state = state_r;
endmodule
`default_nettype wire

// [hdl/tmw_wrap_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Carries the wrap-value port between the top and the buffer module.
interface tmw_wrap_if;
    logic wr_low; // Pulse: write to the low wrap byte.
    logic wr_high; // Pulse: write to the high wrap byte.
    logic [7:0] wdata; // Byte written.
    logic sc_write; // Pulse: any write to status/control.
    logic dbg; // Debug mode active level.
    logic clk_on; // A clock source is selected.
    logic at_update; // Counter is at the update point.
    logic [15:0] active; // Active wrap value.
    logic pending; // One byte written, other outstanding.
    logic [1:0] state; // Latch state for readback.
    modport buffer (
        input wr_low, wr_high, wdata, sc_write, dbg, clk_on, at_update,
        output active, pending, state
    );
    modport core (
        output wr_low, wr_high, wdata, sc_write, dbg, clk_on, at_update,
        input active, pending, state
    );
endinterface
`default_nettype wire
